// *** logic/msc_pkg.sv ***
// package for the modem status-change mask block: offsets, fields, reset values, types
package msc_pkg;
    localparam logic [7:0]  OFS_CTRL     = 8'h00;
    localparam logic [7:0]  OFS_IRQ_STAT = 8'h04;
    localparam logic [7:0]  OFS_IRQ_MASK = 8'h08;
    localparam logic [7:0]  OFS_MASK     = 8'hF4;
    localparam logic [7:0]  OFS_PRESENT  = 8'hF8;

    localparam int POS_IRQ_BIT   = 15;
    localparam int POS_WAKE_BIT  = 14;
    localparam int POS_AUDIO_LO  = 5;
    localparam int POS_GENERAL_WAKE_BIT_BIT = 4;
    localparam int POS_CTRL_CB   = 0;
    localparam int POS_CTRL_MC   = 1;
    localparam int POS_CTRL_PME  = 2;

    localparam logic [1:0]  AUDIO_RESET  = 2'h0;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
    localparam int          EVT_W        = 2;

    typedef struct packed {
        logic pme_en;
        logic modem_ctrl_en;
        logic cardbus_mode;
    } msc_ctrl_s;

    typedef struct packed {
        logic       irq_mask;
        logic       wake_mask;
        logic [1:0] binary_audio_enable;
        logic       general_wake;
    } msc_mask_s;

    localparam msc_ctrl_s CTRL_RESET = '{pme_en: 1'b0, modem_ctrl_en: 1'b0, cardbus_mode: 1'b1};
    localparam msc_mask_s MASK_RESET = '{irq_mask: 1'b0, wake_mask: 1'b0,
                                         binary_audio_enable: AUDIO_RESET, general_wake: 1'b0};
endpackage : msc_pkg

// *** logic/msc_sync.sv ***
// three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module msc_sync #(
    parameter int W = 2
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // per bit: a glitch on s2 alone never reaches dout
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dout <= '0;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2[i] == s3[i]) begin
                    dout[i] <= s3[i];
                end
            end
        end
    end
endmodule : msc_sync

// *** logic/msc_top.sv ***
// modem status-change masking, present state and axi4-lite register slave
`timescale 1ns/1ps
module msc_top #(
    parameter int ADDR_W = 8
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    input  wire logic              modem_irq_in,
    input  wire logic              modem_ring_n,
    output logic                   modem_inta_n,
    output logic                   cstschg,
    output logic                   irq
);
    import msc_pkg::*;

    logic [ADDR_W-1:0]   aw_addr;
    logic                aw_held;
    logic [31:0]         w_data;
    logic [3:0]          w_strb;
    logic                w_held;
    logic                wr_go;
    logic                aw_fire;
    logic                w_fire;
    logic                ar_fire;
    msc_ctrl_s           ctrl;
    msc_mask_s           mask;
    logic                mask_written;
    logic [EVT_W-1:0]    irq_stat;
    logic [EVT_W-1:0]    irq_mask;
    logic [EVT_W-1:0]    pins;
    logic [EVT_W-1:0]    pins_q;
    logic [EVT_W-1:0]    evt;
    logic                irq_live;
    logic                ring_live;
    logic                int_allow;
    logic                wake_allow;
    logic                modem_ring_n_sync_hi;

    function automatic logic [7:0] word_ofs(input logic [ADDR_W-1:0] a);
        return {a[7:2], 2'b00};
    endfunction : word_ofs

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        logic [7:0] o;
        o = word_ofs(a);
        return (o == OFS_CTRL) || (o == OFS_IRQ_STAT) || (o == OFS_IRQ_MASK) ||
               (o == OFS_MASK) || (o == OFS_PRESENT);
    endfunction : mapped

    // ring inverted ahead of the synchroniser: its reset value then matches the idle pin,
    // so no phantom ring shows after reset
    msc_sync #(.W(EVT_W)) u_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     ({~modem_ring_n, modem_irq_in}),
        .dout    (pins)
    );
    assign irq_live  = pins[0];
    assign ring_live = pins[1];

    assign aw_fire = awvalid && awready;
    assign w_fire  = wvalid && wready;
    assign ar_fire = arvalid && arready;
    // synchronised ring pin in its own active-low sense, for the readback check
    assign modem_ring_n_sync_hi = ~pins[1];
    assign wr_go   = aw_held && w_held && !bvalid;

    // write address and data are taken in either order, then answered together
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
            awready <= 1'b0;
        end else begin
            if (aw_fire) begin
                aw_held <= 1'b1;
                aw_addr <= awaddr;
            end else if (bvalid && bready) begin
                aw_held <= 1'b0;
            end
            awready <= !aw_fire && !(aw_held && !(bvalid && bready));
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
            wready <= 1'b0;
        end else begin
            if (w_fire) begin
                w_held <= 1'b1;
                w_data <= wdata;
                w_strb <= wstrb;
            end else if (bvalid && bready) begin
                w_held <= 1'b0;
            end
            wready <= !w_fire && !(w_held && !(bvalid && bready));
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid <= 1'b1;
            bresp  <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // power-up reset only; there is no separate bus reset input
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= CTRL_RESET;
        end else if (wr_go && word_ofs(aw_addr) == OFS_CTRL && w_strb[0]) begin
            ctrl.cardbus_mode  <= w_data[POS_CTRL_CB];
            ctrl.modem_ctrl_en <= w_data[POS_CTRL_MC];
            ctrl.pme_en        <= w_data[POS_CTRL_PME];
        end
    end

    // only the defined bits are stored, so reserved bits drop and read zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask         <= MASK_RESET;
            mask_written <= 1'b0;
        end else if (wr_go && word_ofs(aw_addr) == OFS_MASK && ctrl.cardbus_mode) begin
            mask_written <= 1'b1;
            if (w_strb[0]) begin
                mask.binary_audio_enable <= w_data[POS_AUDIO_LO +: 2];
                mask.general_wake        <= w_data[POS_GENERAL_WAKE_BIT_BIT];
            end
            if (w_strb[1]) begin
                mask.irq_mask  <= w_data[POS_IRQ_BIT];
                mask.wake_mask <= w_data[POS_WAKE_BIT];
            end
        end
    end

    // gating never alters any event state, only the output lines
    assign int_allow  = ctrl.cardbus_mode && ctrl.modem_ctrl_en &&
                        (mask.irq_mask || !mask_written);
    assign wake_allow = ctrl.cardbus_mode &&
                        ((mask.wake_mask && mask.general_wake) || ctrl.pme_en);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            modem_inta_n <= 1'b1;
            cstschg      <= 1'b0;
        end else begin
            modem_inta_n <= !(irq_live && int_allow);
            cstschg      <= ring_live && wake_allow;
        end
    end

    // events: rising modem interrupt, ring assertion
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pins_q <= '0;
        end else begin
            pins_q <= pins;
        end
    end
    assign evt = pins & ~pins_q;

    // set wins over a same-cycle write-one clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat <= '0;
        end else if (wr_go && word_ofs(aw_addr) == OFS_IRQ_STAT && w_strb[0]) begin
            irq_stat <= (irq_stat & ~w_data[EVT_W-1:0]) | evt;
        end else begin
            irq_stat <= irq_stat | evt;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask <= '0;
        end else if (wr_go && word_ofs(aw_addr) == OFS_IRQ_MASK && w_strb[0]) begin
            irq_mask <= w_data[EVT_W-1:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat & irq_mask);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
        end else begin
            arready <= !ar_fire && !(rvalid && !rready);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= '0;
            rresp  <= RESP_OKAY;
        end else if (ar_fire) begin
            rvalid <= 1'b1;
            rresp  <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
            rdata  <= '0;
            case (word_ofs(araddr))
                OFS_CTRL: begin
                    rdata[POS_CTRL_CB]  <= ctrl.cardbus_mode;
                    rdata[POS_CTRL_MC]  <= ctrl.modem_ctrl_en;
                    rdata[POS_CTRL_PME] <= ctrl.pme_en;
                end
                OFS_IRQ_STAT: begin
                    rdata[EVT_W-1:0] <= irq_stat;
                end
                OFS_IRQ_MASK: begin
                    rdata[EVT_W-1:0] <= irq_mask;
                end
                OFS_MASK: begin
                    rdata[POS_IRQ_BIT]        <= mask.irq_mask;
                    rdata[POS_WAKE_BIT]       <= mask.wake_mask;
                    rdata[POS_AUDIO_LO +: 2]  <= mask.binary_audio_enable;
                    rdata[POS_GENERAL_WAKE_BIT_BIT]      <= mask.general_wake;
                end
                OFS_PRESENT: begin
                    rdata[POS_IRQ_BIT]   <= irq_live;
                    rdata[POS_GENERAL_WAKE_BIT_BIT] <= ring_live;
                end
                default: begin
                    rdata <= '0;
                end
            endcase
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    irq_mask_blk_a: assert property (mask_written && !mask.irq_mask |=> modem_inta_n)
        else $error("interrupt line asserted while masked");
    ctrl_gate_a: assert property (!ctrl.modem_ctrl_en |=> modem_inta_n)
        else $error("interrupt line asserted without modem control enable");
    legacy_unmask_a: assert property (!mask_written && ctrl.cardbus_mode && ctrl.modem_ctrl_en
                                      && irq_live |=> !modem_inta_n)
        else $error("interrupt blocked before first mask write");
    wake_blk_a: assert property (!mask.wake_mask && !ctrl.pme_en |=> !cstschg)
        else $error("status change asserted with wake mask clear");
    general_wake_bit_blk_a: assert property (!mask.general_wake && !ctrl.pme_en |=> !cstschg)
        else $error("status change asserted with general wake clear");
    wake_pair_a: assert property (ring_live && ctrl.cardbus_mode && mask.wake_mask
                                  && mask.general_wake |=> cstschg)
        else $error("status change missing with both wake bits set");
    pme_path_a: assert property (ring_live && ctrl.cardbus_mode && ctrl.pme_en |=> cstschg)
        else $error("status change missing with power enable set");
    cb_mode_a: assert property (!ctrl.cardbus_mode |=> modem_inta_n && !cstschg)
        else $error("outputs active outside card bus mode");
    present_rd_a: assert property (ar_fire && word_ofs(araddr) == OFS_PRESENT
                                   |=> rdata[14:5] == '0 && rdata[31:16] == '0
                                   && rdata[3:0] == '0 && rdata[15] == $past(irq_live))
        else $error("present state read wrong");
    ring_rd_a: assert property (ar_fire && word_ofs(araddr) == OFS_PRESENT
                                |=> rdata[4] == !$past(modem_ring_n_sync_hi))
        else $error("ring present bit not inverted");
    mask_rd_a: assert property (ar_fire && word_ofs(araddr) == OFS_MASK
                                |=> rdata[31:16] == '0 && rdata[13:7] == '0
                                && rdata[3:0] == '0)
        else $error("mask reserved bits not zero");
    audio_rst_a: assert property ($rose(aresetn) |-> mask.binary_audio_enable == AUDIO_RESET
                                  && !mask_written)
        else $error("audio field not reset");
    resp_bound_a: assert property (aw_fire && w_fire |-> ##[1:2] bvalid)
        else $error("write response late");
    stat_set_a: assert property (|evt |=> (irq_stat & $past(evt)) == $past(evt))
        else $error("event lost against a same-cycle clear");
    irq_level_a: assert property (1'b1 |=> irq == $past(|(irq_stat & irq_mask)))
        else $error("interrupt output does not follow status and mask");
    aw_hold_a: assert property (aw_held |-> !awready)
        else $error("write address accepted while one is pending");
    b_once_a: assert property (bvalid && bready |=> !bvalid)
        else $error("write response repeated");
    r_once_a: assert property (rvalid && rready |=> !rvalid)
        else $error("read response repeated");

    inta_cov: cover property (!modem_inta_n);
    wake_cov: cover property (cstschg && !ctrl.pme_en);
    stat_cov: cover property (irq && bvalid);
    legacy_cov: cover property (!mask_written && !modem_inta_n);
    ring_evt_cov: cover property (evt[1]);
endmodule : msc_top

// *** sim/msc_modem_model.sv ***
// modem chipset model driving the interrupt and ring pins
`timescale 1ns/1ps
module msc_modem_model #(
    parameter int LAG = 2
) (
    input  wire logic aclk,
    input  wire logic irq_req,
    input  wire logic ring_req,
    output logic      modem_irq_in,
    output logic      modem_ring_n
);
    // lag of LAG cycles: the chipset answers slowly and never in step with a request
    logic [LAG-1:0] irq_q  = '0;
    logic [LAG-1:0] ring_q = '0;

    always_ff @(posedge aclk) begin
        irq_q  <= {irq_q[LAG-2:0], irq_req};
        ring_q <= {ring_q[LAG-2:0], ring_req};
    end

    // levels always driven by the chipset, so there is no released state
    assign modem_irq_in = irq_q[LAG-1];
    assign modem_ring_n = ~ring_q[LAG-1];
endmodule : msc_modem_model

// *** sim/modem_status_change_mask_test.sv ***
// self-checking bench for the modem status-change mask block
`timescale 1ns/1ps
module modem_status_change_mask_test;
    import msc_pkg::*;
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] wr;
        logic [31:0] rd;
        logic        inta_n;
        logic        chg;
    } msc_row_s;

    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = '0;
    logic [7:0]  araddr = '0;
    logic [31:0] wdata = '0;
    logic [3:0]  wstrb = 4'hF;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        irq_req = 1'b0, ring_req = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, irq_pin, ring_n, inta_n, cstschg, irq;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    int          mismatches = 0;
    int          comparisons = 0;
    int          cycles = 0;

    // ctrl, mask write, mask readback, modem_inta_n, cstschg; pins held active
    msc_row_s rows [7] = '{
        '{32'h0000_0003, 32'hFFFF_FFFF, 32'h0000_C070, 1'b0, 1'b1},
        '{32'h0000_0003, 32'h0000_4010, 32'h0000_4010, 1'b1, 1'b1},
        '{32'h0000_0001, 32'h0000_8000, 32'h0000_8000, 1'b1, 1'b0},
        '{32'h0000_0003, 32'h0000_8010, 32'h0000_8010, 1'b0, 1'b0},
        '{32'h0000_0003, 32'h0000_C000, 32'h0000_C000, 1'b0, 1'b0},
        '{32'h0000_0005, 32'h0000_0040, 32'h0000_0040, 1'b1, 1'b1},
        '{32'h0000_0006, 32'h0000_C010, 32'h0000_0040, 1'b1, 1'b0}
    };

    msc_top #(.ADDR_W(8)) msc_top_i (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .modem_irq_in(irq_pin), .modem_ring_n(ring_n), .modem_inta_n(inta_n),
        .cstschg(cstschg), .irq(irq)
    );

    msc_modem_model #(.LAG(3)) msc_modem_model_i (
        .aclk(aclk), .irq_req(irq_req), .ring_req(ring_req),
        .modem_irq_in(irq_pin), .modem_ring_n(ring_n)
    );

    initial begin
        forever #50 aclk = ~aclk;
    end

    task automatic end_of_test;
        if (mismatches == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_word

    task automatic cmp_pin(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: pin %h expected %h", $time, got, exp);
        end
    endtask : cmp_pin

    // each channel released at its own handshake; an edge passes before the next access
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        cmp_word({30'h0, bresp}, {30'h0, er});
        @(posedge aclk);
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        cmp_word(rdata, exp);
        cmp_word({30'h0, rresp}, {30'h0, er});
        @(posedge aclk);
    endtask : bus_rd

    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        bus_rd(OFS_MASK, 32'h0000_0000, RESP_OKAY);
        bus_rd(OFS_PRESENT, 32'h0000_0000, RESP_OKAY);
        bus_rd(OFS_CTRL, 32'h0000_0001, RESP_OKAY);
        // mask never written yet, so the interrupt must pass
        bus_wr(OFS_CTRL, 32'h0000_0003, RESP_OKAY);
        bus_wr(OFS_IRQ_MASK, 32'h0000_0000, RESP_OKAY);
        irq_req  <= 1'b1;
        ring_req <= 1'b1;
        repeat (12) @(posedge aclk);
        cmp_pin(inta_n, 1'b0);
        cmp_pin(cstschg, 1'b0);
        cmp_pin(irq, 1'b0);
        bus_rd(OFS_PRESENT, 32'h0000_8010, RESP_OKAY);
        bus_rd(OFS_IRQ_STAT, 32'h0000_0003, RESP_OKAY);
        bus_wr(OFS_IRQ_MASK, 32'h0000_0001, RESP_OKAY);
        repeat (2) @(posedge aclk);
        cmp_pin(irq, 1'b1);
        bus_wr(OFS_IRQ_STAT, 32'h0000_0003, RESP_OKAY);
        repeat (2) @(posedge aclk);
        cmp_pin(irq, 1'b0);
        bus_rd(OFS_IRQ_STAT, 32'h0000_0000, RESP_OKAY);
        foreach (rows[i]) begin
            bus_wr(OFS_CTRL, rows[i].ctrl, RESP_OKAY);
            bus_wr(OFS_MASK, rows[i].wr, RESP_OKAY);
            repeat (8) @(posedge aclk);
            bus_rd(OFS_MASK, rows[i].rd, RESP_OKAY);
            cmp_pin(inta_n, rows[i].inta_n);
            cmp_pin(cstschg, rows[i].chg);
        end
        irq_req  <= 1'b0;
        ring_req <= 1'b0;
        repeat (12) @(posedge aclk);
        bus_rd(OFS_PRESENT, 32'h0000_0000, RESP_OKAY);
        // second power-up reset in mid-run
        aresetn <= 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        bus_rd(OFS_MASK, 32'h0000_0000, RESP_OKAY);
        bus_rd(OFS_CTRL, 32'h0000_0001, RESP_OKAY);
        bus_wr(8'h40, 32'hFFFF_FFFF, RESP_SLVERR);
        bus_rd(8'h40, 32'h0000_0000, RESP_SLVERR);
        end_of_test();
    end

    // whole run needs well under a thousand cycles
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches++;
            end_of_test();
        end
    end
endmodule : modem_status_change_mask_test
